// ===== design/hrc_highway_cfg.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: Output enable bit 2, reset zero, drives
// RULE2: Global external-drive setting qualifies the enable
// RULE3: Rate codes 2, 4, 8 Mbit/s, idle
// RULE4: Unused upper bits always read zero
// RULE5: Host clears global enable during clock loss
// RULE6: Host re-enables only after lock, 250 us
// RULE7: Whole-bit shift delays frame by bits
// RULE8: Quarter-bit shift delays frame quarter steps
// RULE9: Bit periods follow each highway's rate
// RULE10: Slot, bit, quarter shifts add together
// RULE11: Host writes zero to two low bits
// RULE12: Host uses zero whole-bit shift when unneeded
// RULE13: Slot shift limited by rate: 31/63/127
// RULE14: Quarter ticks from four-times-fastest reference
module hrc_highway_cfg #(
  parameter int unsigned HWY_COUNT = hrc_pkg::HWY_COUNT,
  parameter int unsigned ADDR_W = hrc_pkg::ADDR_W
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic host_cs_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic [7:0] host_wdata_in,
  output logic [7:0] host_rdata_out,
  input wire logic global_tx_output_enable_in,
  input wire logic external_drive_in,
  input wire logic highway_clock_in,
  input wire logic frame_sync_in,
  input wire logic [2*HWY_COUNT-1:0] rx_rate_in,
  input wire logic [7*HWY_COUNT-1:0] rx_slot_shift_in,
  output logic [HWY_COUNT-1:0] tx_driver_enable_out,
  output logic [HWY_COUNT-1:0] tx_output_enable_out,
  output logic [2*HWY_COUNT-1:0] highway_rate_select_out,
  output logic [HWY_COUNT-1:0] rx_sample_start_out
);
  localparam int unsigned IDX_W = $clog2(HWY_COUNT);

  // Host address hits one highway's byte of the given bank
  function automatic logic hwy_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [15:0] base);
    logic [ADDR_W-1:0] d;
    d = addr - ADDR_W'(base);
    return addr >= ADDR_W'(base) && d[1:0] == 2'h0
      && (d >> hrc_pkg::HWY_STRIDE_SHIFT) < ADDR_W'(HWY_COUNT);
  endfunction

  // Highway number of an address in the given bank
  function automatic logic [IDX_W-1:0] hwy_index(
      input logic [ADDR_W-1:0] addr, input logic [15:0] base);
    logic [ADDR_W-1:0] d;
    d = (addr - ADDR_W'(base)) >> hrc_pkg::HWY_STRIDE_SHIFT;
    return d[IDX_W-1:0];
  endfunction

  // Largest slot shift allowed at a rate
  function automatic logic [6:0] slot_limit(input logic [1:0] rate);
    unique case (rate)
      hrc_pkg::RATE_4M: return hrc_pkg::SLOT_MAX_4M;
      hrc_pkg::RATE_8M: return hrc_pkg::SLOT_MAX_8M;
      default: return hrc_pkg::SLOT_MAX_2M;
    endcase
  endfunction

  logic [2:0] tx_cfg_ff [HWY_COUNT];
  logic [2:0] nxt_tx_cfg_ff [HWY_COUNT];
  logic [6:0] rx_ofs_ff [HWY_COUNT];
  logic [6:0] nxt_rx_ofs_ff [HWY_COUNT];
  logic [7:0] nxt_host_rdata;
  logic tx_wr_hit, rx_wr_hit, tx_rd_hit, rx_rd_hit;
  logic [IDX_W-1:0] acc_idx_tx, acc_idx_rx;

  // Host register writes and registered read data
  always_comb begin
    tx_wr_hit = host_cs_in && host_wr_in
      && hwy_hit(host_addr_in, hrc_pkg::TX_CFG_BASE);
    rx_wr_hit = host_cs_in && host_wr_in
      && hwy_hit(host_addr_in, hrc_pkg::RX_OFS_BASE);
    tx_rd_hit = host_cs_in && host_rd_in
      && hwy_hit(host_addr_in, hrc_pkg::TX_CFG_BASE);
    rx_rd_hit = host_cs_in && host_rd_in
      && hwy_hit(host_addr_in, hrc_pkg::RX_OFS_BASE);
    acc_idx_tx = hwy_index(host_addr_in, hrc_pkg::TX_CFG_BASE);
    acc_idx_rx = hwy_index(host_addr_in, hrc_pkg::RX_OFS_BASE);
    nxt_tx_cfg_ff = tx_cfg_ff;
    nxt_rx_ofs_ff = rx_ofs_ff;
    nxt_host_rdata = 8'h00;
    if (tx_wr_hit) begin
      nxt_tx_cfg_ff[acc_idx_tx] = host_wdata_in[hrc_pkg::TX_CFG_W-1:0];
    end
    if (rx_wr_hit) begin
      nxt_rx_ofs_ff[acc_idx_rx] = host_wdata_in[hrc_pkg::RX_OFS_W-1:0];
    end
    if (tx_rd_hit) begin
      nxt_host_rdata = {5'h00, tx_cfg_ff[acc_idx_tx]}; // RULE4
    end else if (rx_rd_hit) begin
      nxt_host_rdata = {1'b0, rx_ofs_ff[acc_idx_rx]}; // RULE4 RULE11
    end
  end

  // Configuration storage
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < HWY_COUNT; i++) begin
        tx_cfg_ff[i] <= hrc_pkg::TX_CFG_RESET; // RULE1
        rx_ofs_ff[i] <= hrc_pkg::RX_OFS_RESET;
      end
      host_rdata_out <= 8'h00;
    end else begin
      tx_cfg_ff <= nxt_tx_cfg_ff;
      rx_ofs_ff <= nxt_rx_ofs_ff;
      host_rdata_out <= nxt_host_rdata;
    end
  end

  logic hclk_s1_ff, hclk_s2_ff, hclk_s3_ff;
  logic fsync_s1_ff, fsync_s2_ff, fsync_s3_ff;
  logic qtick, frame_start;

  // Two-stage synchronisers and rising-edge detect
  always_comb begin
    qtick = hclk_s2_ff && !hclk_s3_ff; // RULE14
    frame_start = fsync_s2_ff && !fsync_s3_ff;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hclk_s1_ff <= 1'b0;
      hclk_s2_ff <= 1'b0;
      hclk_s3_ff <= 1'b0;
      fsync_s1_ff <= 1'b0;
      fsync_s2_ff <= 1'b0;
      fsync_s3_ff <= 1'b0;
    end else begin
      hclk_s1_ff <= highway_clock_in;
      hclk_s2_ff <= hclk_s1_ff;
      hclk_s3_ff <= hclk_s2_ff;
      fsync_s1_ff <= frame_sync_in;
      fsync_s2_ff <= fsync_s1_ff;
      fsync_s3_ff <= fsync_s2_ff;
    end
  end

  logic [HWY_COUNT-1:0] nxt_tx_driver_enable, nxt_tx_output_enable;
  logic [2*HWY_COUNT-1:0] nxt_highway_rate_select;

  // Per-highway transmit driver qualification
  always_comb begin
    for (int i = 0; i < HWY_COUNT; i++) begin
      nxt_highway_rate_select[2*i +: 2] =
        tx_cfg_ff[i][hrc_pkg::TX_RATE_LSB +: 2]; // RULE3
      nxt_tx_output_enable[i] = global_tx_output_enable_in
        && tx_cfg_ff[i][hrc_pkg::TX_OE_BIT]; // RULE1
      nxt_tx_driver_enable[i] = global_tx_output_enable_in
        && (tx_cfg_ff[i][hrc_pkg::TX_OE_BIT] || external_drive_in)
        && tx_cfg_ff[i][hrc_pkg::TX_RATE_LSB +: 2]
           != hrc_pkg::RATE_IDLE; // RULE2 RULE3
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_driver_enable_out <= '0;
      tx_output_enable_out <= '0;
      highway_rate_select_out <= '0;
    end else begin
      tx_driver_enable_out <= nxt_tx_driver_enable;
      tx_output_enable_out <= nxt_tx_output_enable;
      highway_rate_select_out <= nxt_highway_rate_select;
    end
  end

  // One frame timer per receive highway
  for (genvar g = 0; g < HWY_COUNT; g++) begin : g_rx
    logic [1:0] rate_w;
    logic [6:0] slot_w;
    assign rate_w = rx_rate_in[2*g +: 2];
    assign slot_w = rx_slot_shift_in[7*g +: 7]
                    & slot_limit(rate_w); // RULE13
    hrc_rx_frame_timer #(.DELAY_W(hrc_pkg::DELAY_W)) u_tmr (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .qtick_in(qtick),
      .frame_start_in(frame_start),
      .rate_in(rate_w),
      .slot_in(slot_w),
      .wbit_in(rx_ofs_ff[g][hrc_pkg::RX_WBIT_LSB +: 3]),
      .qbit_in(rx_ofs_ff[g][hrc_pkg::RX_QBIT_LSB +: 2]),
      .sample_start_out(rx_sample_start_out[g])
    );

    property p_slot_clamp;
      @(posedge mclk_in) disable iff (rst_in)
      slot_w <= slot_limit(rate_w);
    endproperty
    a_slot_clamp: assert property (p_slot_clamp) // RULE13
      else $error("slot shift beyond rate limit");
  end

  property p_oe_off;
    @(posedge mclk_in) disable iff (rst_in)
    !tx_cfg_ff[0][hrc_pkg::TX_OE_BIT] && !external_drive_in
      |=> !tx_driver_enable_out[0];
  endproperty
  a_oe_off: assert property (p_oe_off) // RULE1
    else $error("driver on with enable bit clear");

  property p_global_off;
    @(posedge mclk_in) disable iff (rst_in)
    !global_tx_output_enable_in |=> tx_driver_enable_out == '0
      && tx_output_enable_out == '0;
  endproperty
  a_global_off: assert property (p_global_off) // RULE2
    else $error("driver on with global enable clear");

  property p_ext_drive;
    @(posedge mclk_in) disable iff (rst_in)
    global_tx_output_enable_in && external_drive_in
      && tx_cfg_ff[0][hrc_pkg::TX_RATE_LSB +: 2] != hrc_pkg::RATE_IDLE
      |=> tx_driver_enable_out[0];
  endproperty
  a_ext_drive: assert property (p_ext_drive) // RULE2
    else $error("external drive did not enable driver");

  property p_tx_idle;
    @(posedge mclk_in) disable iff (rst_in)
    tx_cfg_ff[0][hrc_pkg::TX_RATE_LSB +: 2] == hrc_pkg::RATE_IDLE
      |=> !tx_driver_enable_out[0];
  endproperty
  a_tx_idle: assert property (p_tx_idle) // RULE3
    else $error("idle highway driver enabled");

  property p_rd_zero;
    @(posedge mclk_in) disable iff (rst_in)
    tx_rd_hit |=> host_rdata_out[7:3] == 5'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) // RULE4
    else $error("transmit byte upper bits not zero");
endmodule

// ===== design/hrc_pkg.sv
package hrc_pkg;
  // Highway count and host address layout
  localparam int unsigned HWY_COUNT = 32;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] TX_CFG_BASE = 16'h1002;
  localparam logic [15:0] RX_OFS_BASE = 16'h1801;
  localparam int unsigned HWY_STRIDE_SHIFT = 2;

  // Transmit configuration byte fields
  localparam int unsigned TX_OE_BIT = 2;
  localparam int unsigned TX_RATE_LSB = 0;
  localparam int unsigned TX_CFG_W = 3;
  localparam logic [2:0] TX_CFG_RESET = 3'h0;

  // Receive offset byte fields
  localparam int unsigned RX_WBIT_LSB = 4;
  localparam int unsigned RX_QBIT_LSB = 2;
  localparam int unsigned RX_OFS_W = 7;
  localparam logic [6:0] RX_OFS_RESET = 7'h00;

  // Rate codes
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_IDLE = 2'h3;

  // Largest slot shift per rate
  localparam logic [6:0] SLOT_MAX_2M = 7'h1F;
  localparam logic [6:0] SLOT_MAX_4M = 7'h3F;
  localparam logic [6:0] SLOT_MAX_8M = 7'h7F;

  // Quarter-bit tick arithmetic
  localparam int unsigned DELAY_W = 12;
  localparam int unsigned QBIT_SHIFT = 2;
  localparam int unsigned SLOT_SHIFT = 5;

  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_ARMED = 1'b1
  } hrc_tmr_state_type;
endpackage

// ===== design/hrc_rx_frame_timer.sv
`timescale 1ns/1ps
module hrc_rx_frame_timer #(
  parameter int unsigned DELAY_W = hrc_pkg::DELAY_W
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic qtick_in,
  input wire logic frame_start_in,
  input wire logic [1:0] rate_in,
  input wire logic [6:0] slot_in,
  input wire logic [2:0] wbit_in,
  input wire logic [1:0] qbit_in,
  output logic sample_start_out
);
  hrc_pkg::hrc_tmr_state_type state_ff, nxt_state_ff;
  logic [DELAY_W-1:0] cnt_ff, nxt_cnt_ff;
  logic nxt_sample_start;
  logic [DELAY_W-1:0] base_w, delay_w;

  // Sum of slot, whole bit and quarter bit in quarter-bit units
  always_comb begin
    base_w = {slot_in[DELAY_W-hrc_pkg::SLOT_SHIFT-1:0],
              {hrc_pkg::SLOT_SHIFT{1'b0}}}
           + DELAY_W'({wbit_in, {hrc_pkg::QBIT_SHIFT{1'b0}}})
           + DELAY_W'(qbit_in); // RULE10 RULE7 RULE8
    unique case (rate_in)
      hrc_pkg::RATE_4M: delay_w = {base_w[DELAY_W-2:0], 1'b0}; // RULE9
      hrc_pkg::RATE_2M: delay_w = {base_w[DELAY_W-3:0], 2'b00}; // RULE9
      default: delay_w = base_w;
    endcase
  end

  // Countdown of reference ticks from frame sync to slot 0 bit 0
  always_comb begin
    nxt_state_ff = state_ff;
    nxt_cnt_ff = cnt_ff;
    nxt_sample_start = 1'b0;
    unique case (state_ff)
      hrc_pkg::TMR_IDLE: begin
        if (frame_start_in && rate_in != hrc_pkg::RATE_IDLE) begin
          if (delay_w == '0) begin
            nxt_sample_start = 1'b1;
          end else begin
            nxt_cnt_ff = delay_w;
            nxt_state_ff = hrc_pkg::TMR_ARMED;
          end
        end
      end
      hrc_pkg::TMR_ARMED: begin
        if (rate_in == hrc_pkg::RATE_IDLE) begin
          nxt_state_ff = hrc_pkg::TMR_IDLE; // RULE3
        end else if (frame_start_in) begin
          if (delay_w == '0) begin
            nxt_sample_start = 1'b1;
            nxt_state_ff = hrc_pkg::TMR_IDLE;
          end else begin
            nxt_cnt_ff = delay_w;
          end
        end else if (qtick_in) begin
          nxt_cnt_ff = cnt_ff - DELAY_W'(1);
          if (cnt_ff == DELAY_W'(1)) begin
            nxt_sample_start = 1'b1; // RULE14
            nxt_state_ff = hrc_pkg::TMR_IDLE;
          end
        end
      end
    endcase
  end

  // Timer registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= hrc_pkg::TMR_IDLE;
      cnt_ff <= '0;
      sample_start_out <= 1'b0;
    end else begin
      state_ff <= nxt_state_ff;
      cnt_ff <= nxt_cnt_ff;
      sample_start_out <= nxt_sample_start;
    end
  end

  // Helper: ticks seen since the last frame sync
  logic [DELAY_W:0] seen_ff;
  logic [DELAY_W-1:0] want_ff;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_ff <= '0;
      want_ff <= '0;
    end else if (frame_start_in) begin
      seen_ff <= '0;
      want_ff <= delay_w;
    end else if (qtick_in) begin
      seen_ff <= seen_ff + (DELAY_W+1)'(1);
    end
  end

  property p_delay_count;
    @(posedge mclk_in) disable iff (rst_in)
    sample_start_out |-> seen_ff == {1'b0, want_ff};
  endproperty
  a_delay_count: assert property (p_delay_count) // RULE10
    else $error("slot 0 bit 0 strobe at wrong tick count");

  property p_zero_delay;
    @(posedge mclk_in) disable iff (rst_in)
    frame_start_in && rate_in != hrc_pkg::RATE_IDLE && slot_in == '0
      && wbit_in == '0 && qbit_in == '0 |=> sample_start_out;
  endproperty
  a_zero_delay: assert property (p_zero_delay) // RULE7
    else $error("zero offset did not strobe at once");

  property p_rx_idle;
    @(posedge mclk_in) disable iff (rst_in)
    rate_in == hrc_pkg::RATE_IDLE |=> !sample_start_out;
  endproperty
  a_rx_idle: assert property (p_rx_idle) // RULE3
    else $error("idle highway produced a sample strobe");
endmodule

// ===== tb/hrc_peer_model.sv
`timescale 1ns/1ps
module hrc_peer_model #(
  // Relock wait in mclk cycles: 250 us at 8 ns
  parameter int RELOCK = 31250
) (
  input wire logic mclk_in,
  input wire logic clk_run_in,
  input wire logic host_global_in,
  input wire logic frame_go_in,
  output logic highway_clock_out,
  output logic frame_sync_out,
  output logic global_en_out
);
  int lock_cnt = RELOCK; // Reference already locked at start
  // Quarter-bit reference, parked low while stopped
  initial begin
    highway_clock_out = 1'b0;
    #3;
    forever #16 highway_clock_out = clk_run_in & ~highway_clock_out;
  end
  // Host view of the reference: lost drops lock, relock takes time
  always @(posedge mclk_in) begin
    if (!clk_run_in)
      lock_cnt <= 0;
    else if (lock_cnt < RELOCK)
      lock_cnt <= lock_cnt + 1;
  end
  // Global enable only offered once locked
  assign global_en_out = host_global_in && lock_cnt >= RELOCK;
  // Frame sync follows the bench request
  assign frame_sync_out = frame_go_in;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int N = hrc_pkg::HWY_COUNT;
  localparam int RELOCK = 31250;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic host_glb = 1'b0;
  logic ext = 1'b0;
  logic run = 1'b1;
  logic fgo = 1'b0;
  logic hclk, fsync, glb;
  logic [2*N-1:0] rrate = '0;
  logic [7*N-1:0] rslot = '0;
  logic [N-1:0] drv, oen, pulse;
  logic [2*N-1:0] rsel;
  logic [7:0] expq[$];
  logic rd_q = 1'b0;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;

  // Clock
  always #4 mclk = ~mclk;

  hrc_peer_model #(.RELOCK(RELOCK)) peer (.mclk_in(mclk), .clk_run_in(run),
    .host_global_in(host_glb), .frame_go_in(fgo),
    .highway_clock_out(hclk), .frame_sync_out(fsync),
    .global_en_out(glb));

  hrc_highway_cfg dut (.mclk_in(mclk), .rst_in(rst), .host_cs_in(cs),
    .host_wr_in(wr), .host_rd_in(rd), .host_addr_in(addr),
    .host_wdata_in(wdata), .host_rdata_out(rdata),
    .global_tx_output_enable_in(glb), .external_drive_in(ext),
    .highway_clock_in(hclk), .frame_sync_in(fsync),
    .rx_rate_in(rrate), .rx_slot_shift_in(rslot),
    .tx_driver_enable_out(drv), .tx_output_enable_out(oen),
    .highway_rate_select_out(rsel), .rx_sample_start_out(pulse));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One host access held for a single edge, then one idle edge
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    cs = 1'b1;
    wr = w;
    rd = ~w;
    addr = a;
    wdata = d;
    cyc_wait(1);
    cs = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    cyc_wait(1);
  endtask

  // Read with its expected byte noted first
  task automatic rdx(input logic [15:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask

  // Frame start to sample point, counted from the pin edge
  task automatic frm(input logic [1:0] r, input logic [6:0] s,
    input logic [2:0] wb, input logic [1:0] qb, input int d);
    int n;
    acc(1'b1, hrc_pkg::RX_OFS_BASE + 16'h0008, {1'b0, wb, qb, 2'h0});
    rrate[5:4] = r;
    rslot[20:14] = s;
    fgo = 1'b1;
    n = 0;
    while (n < 700 && pulse[2] !== 1'b1) begin
      cyc_wait(1);
      n++;
      if (n == 8)
        fgo = 1'b0;
    end
    if (n < 8)
      fgo = 1'b0;
    if (d < 0)
      cmp({7'h00, pulse[2]}, 8'h00);
    else
      cmp({7'h00, n >= 4*d && n <= 4*d+9}, 8'h01);
    cyc_wait(10);
  endtask

  // Read results checked against the oldest note
  always @(posedge mclk) rd_q <= cs & rd;
  always @(negedge mclk) begin
    if (rd_q && expq.size() > 0)
      cmp(rdata, expq.pop_front());
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    logic [7:0] v;
    int h;
    void'($urandom(32'h7598509F));
    repeat (20) @(posedge mclk);
    #1;
    rst = 1'b0;
    // Reset values, reserved bits zero
    for (int i = 0; i < N; i++) begin
      rdx(hrc_pkg::TX_CFG_BASE + 16'(4*i), 8'h00);
      rdx(hrc_pkg::RX_OFS_BASE + 16'(4*i), 8'h00);
    end
    // Random bytes read back through field masks
    repeat (8) begin
      h = $urandom_range(N-1);
      v = 8'($urandom());
      acc(1'b1, hrc_pkg::TX_CFG_BASE + 16'(4*h), v);
      rdx(hrc_pkg::TX_CFG_BASE + 16'(4*h), {5'h00, v[2:0]});
      acc(1'b1, hrc_pkg::RX_OFS_BASE + 16'(4*h), v & 8'hFC);
      rdx(hrc_pkg::RX_OFS_BASE + 16'(4*h), {1'b0, v[6:2], 2'h0});
    end
    // Unmapped place ignores writes and reads zero
    acc(1'b1, 16'h1003, 8'hFF);
    rdx(16'h1003, 8'h00);
    // Every rate code, enable bit, global and external setting
    for (int k = 0; k < 32; k++) begin
      acc(1'b1, hrc_pkg::TX_CFG_BASE, 8'(k[2:0]));
      host_glb = k[3];
      ext = k[4];
      cyc_wait(3);
      cmp({7'h00, drv[0]},
        {7'h00, k[3] & (k[2] | k[4]) & (k[1:0] != 2'h3)});
      cmp({7'h00, oen[0]}, {7'h00, k[3] & k[2]});
      cmp({6'h00, rsel[1:0]}, {6'h00, 2'(k[1:0])});
    end
    // Clock loss withdraws the drivers until relock
    acc(1'b1, hrc_pkg::TX_CFG_BASE, 8'h04);
    host_glb = 1'b1;
    run = 1'b0;
    cyc_wait(3);
    cmp({7'h00, drv[0]}, 8'h00);
    run = 1'b1;
    cyc_wait(50);
    cmp({7'h00, drv[0]}, 8'h00);
    cyc_wait(RELOCK - 60);
    cmp({7'h00, drv[0]}, 8'h00);
    cyc_wait(20);
    cmp({7'h00, drv[0]}, 8'h01);
    // Sample point per rate and offsets
    frm(2'h2, 7'h00, 3'h1, 2'h0, 4);
    frm(2'h1, 7'h00, 3'h1, 2'h1, 10);
    frm(2'h0, 7'h21, 3'h0, 2'h0, 128);
    frm(2'h2, 7'h01, 3'h7, 2'h3, 63);
    frm(2'h3, 7'h00, 3'h0, 2'h0, -1);
    tally_and_finish();
  end
endmodule
